// ### bench/flash_array_model.sv
// Purpose: behavioural flash array behind the sequencer
// Assumes: one request outstanding at a time
// Notes: lat sets answer delay; err and uncorr injected on demand
`timescale 1ns/1ps
module flash_array_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] lat,
  input wire logic inj_err,
  input wire logic inj_unc,
  input wire flash_cmd_pkg::arr_req_t req,
  output flash_cmd_pkg::arr_rsp_t rsp
);
  logic [63:0] mem [logic [22:0]];
  flash_cmd_pkg::arr_req_t held;
  logic busy;
  logic [3:0] cnt;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      rsp <= '0;
    end else if (req.req) begin
      busy <= 1'b1;
      held <= req;
      cnt <= lat;
      rsp <= {1'b0, ~rsp.err, ~rsp.uncorr, ~rsp.rdata};
    end else if (busy && cnt == 4'h0) begin
      busy <= 1'b0;
      rsp.ack <= 1'b1;
      rsp.err <= inj_err;
      rsp.uncorr <= inj_unc;
      if (held.write) mem[held.addr] = held.wdata;
      // eight tagged phrases in info area
      if (held.info) rsp.rdata <= {4'hA, 9'h0, held.addr[5:3], 4'hB, 9'h0, held.addr[5:3],
        4'hC, 9'h0, held.addr[5:3], 4'hD, 9'h0, held.addr[5:3]};
      else rsp.rdata <= mem.exists(held.addr) ? mem[held.addr] : flash_cmd_pkg::ERASED;
    end else begin
      cnt <= cnt - 4'h1;
      // Outside an answer nothing is valid, so keep flipping
      rsp <= {1'b0, ~rsp.err, ~rsp.uncorr, ~rsp.rdata};
    end
  end
endmodule : flash_array_model

// ### bench/flash_cmd_seq_sva.sv
// Purpose: port checks for the flash command sequencer
// Assumes: array answers each request within 40 cycles
// Notes: bound from tb_top
`timescale 1ns/1ps
module flash_cmd_seq_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire flash_cmd_pkg::arr_req_t arr_req_o,
  input wire flash_cmd_pkg::arr_rsp_t arr_rsp_i,
  input wire logic pflash_read_invalid
);
  logic wr_pend_reg;
  logic [22:0] wr_addr_reg;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Remembers the last array request so the read-back can be matched
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 23'h0;
    end else if (arr_req_o.req) begin
      wr_pend_reg <= arr_req_o.write;
      wr_addr_reg <= arr_req_o.addr;
    end
  end
  sequence s_wr_done;
    arr_rsp_i.ack && wr_pend_reg;
  endsequence
  sequence s_readback;
    arr_req_o.req && !arr_req_o.write && arr_req_o.addr == wr_addr_reg;
  endsequence
  chk_ack_after_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_dat_quiet: assert property (!(wb_ack_o && !wb_we_i) |-> wb_dat_o == 32'h0)
    else $error("read data outside read answer");
  chk_req_one_pulse: assert property (arr_req_o.req |=> !arr_req_o.req)
    else $error("array request longer than one cycle");
  chk_pf_range: assert property (
    arr_req_o.req && !arr_req_o.info |-> arr_req_o.addr >= flash_cmd_pkg::PF_START
      && arr_req_o.addr[2:0] == 3'h0) else $error("array address invalid");
  chk_info_field: assert property (
    arr_req_o.req && arr_req_o.info |-> !arr_req_o.write && arr_req_o.addr[22:6] == 17'h0
      && arr_req_o.addr[2:0] == 3'h0) else $error("one-time access outside field");
  chk_info_blank: assert property (arr_req_o.req && arr_req_o.info |=> pflash_read_invalid)
    else $error("flash reads not marked invalid");
  chk_readback: assert property (s_wr_done |-> ##2 s_readback)
    else $error("program not followed by read-back");
endmodule : flash_cmd_seq_sva

// ### bench/tb_top.sv
// Purpose: self-checking bench for the flash command sequencer
// Assumes: Wishbone reads compared on ack from a queue of expectations
// Notes: array model answers promptly first, then slowly
`timescale 1ns/1ps
module tb_top;
  logic clk, rst_n, cyc, stb, we, ack, inv, inj_err, inj_unc;
  logic [4:0] adr;
  logic [3:0] sel, lat;
  logic [31:0] wdat, rdat, lfsr_reg;
  logic [31:0] exp_q [$];
  flash_cmd_pkg::arr_req_t areq;
  flash_cmd_pkg::arr_rsp_t arsp;
  logic [7:0] codes [3] = '{8'h03, 8'h04, 8'h06};
  logic [2:0] idxs [3] = '{3'h2, 3'h1, 3'h5};
  int error_cnt, checked;
  flash_cmd_seq DUT (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .arr_req_o(areq), .arr_rsp_i(arsp), .pflash_read_invalid(inv));
  flash_array_model model_i (.clk(clk), .rst_n(rst_n), .lat(lat), .inj_err(inj_err),
    .inj_unc(inj_unc), .req(areq), .rsp(arsp));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: read %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("mismatches %0d, comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  always @(negedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) check(rdat, exp_q.pop_front());
  end
  task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 100);
    if (n >= 100) error_cnt++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : xfer
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0, q);
  endtask : rd
  task automatic cmd(input logic [7:0] code, input logic [22:0] a, input logic [15:0] w2,
                     input logic [2:0] idx, input logic [31:0] st, input logic keep = 1'b0);
    logic [31:0] q;
    int n;
    logic [15:0] s [6];
    s = '{{code, 1'b0, a[22:16]}, a[15:0], w2, lfsr_reg[15:0], lfsr_reg[31:16], ~w2};
    lfsr_reg = lfsr(lfsr_reg);
    for (int i = 0; i < 6; i++) begin
      wr(flash_cmd_pkg::OFS_INDEX, 32'(i));
      wr(flash_cmd_pkg::OFS_PARAM, {16'h0, s[i]});
    end
    wr(flash_cmd_pkg::OFS_INDEX, {29'h0, idx});
    wr(flash_cmd_pkg::OFS_STATUS, 32'h80);
    n = 0;
    do begin
      xfer(1'b0, flash_cmd_pkg::OFS_STATUS, 32'h0, q);
      n++;
    end while (q[7] !== 1'b1 && n < 50);
    if (n >= 50) error_cnt++;
    rd(flash_cmd_pkg::OFS_STATUS, st);
    if (!keep) wr(flash_cmd_pkg::OFS_STATUS, 32'h30);
  endtask : cmd
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    final_report();
  end
  initial begin
    {rst_n, cyc, stb, we, adr, wdat, lat, inj_err, inj_unc} = '0;
    sel = 4'hF;
    lfsr_reg = 32'h6616;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(flash_cmd_pkg::OFS_STATUS, 32'h80);
    rd(flash_cmd_pkg::OFS_MODE, 32'h7);
    rd(5'h14, 32'h0);
    cmd(8'h06, 23'h7C0010, 16'h1234, 3'h5, 32'h80);
    lat <= 4'h5;
    cmd(8'h03, 23'h7C0000, 16'h0004, 3'h2, 32'h82);
    cmd(8'h03, 23'h7DFFF8, 16'h0001, 3'h2, 32'h80);
    // bench code runs outside the array
    cmd(8'h04, 23'h000005, 16'h0, 3'h1, 32'h80);
    for (int i = 2; i < 6; i++) begin
      wr(flash_cmd_pkg::OFS_INDEX, 32'(i));
      rd(flash_cmd_pkg::OFS_PARAM, {16'h0, 4'(8 + i), 12'h005});
    end
    cmd(8'h03, 23'h7DFFF8, 16'h0002, 3'h2, 32'hA0);
    cmd(8'h03, 23'h7C0000, 16'h0003, 3'h1, 32'hA0);
    cmd(8'h03, 23'h400000, 16'h0001, 3'h2, 32'hA0);
    cmd(8'h06, 23'h7C0004, 16'h0001, 3'h5, 32'hA0);
    cmd(8'h04, 23'h000008, 16'h0, 3'h1, 32'hA0);
    cmd(8'h04, 23'h000007, 16'h0, 3'h2, 32'hA0);
    cmd(8'h06, 23'h7C0020, 16'h0001, 3'h2, 32'hA0);
    for (int k = 0; k < 3; k++) begin
      wr(flash_cmd_pkg::OFS_MODE, 32'h7 ^ (32'h1 << k));
      cmd(codes[k], 23'h7C0200 >> (k == 1 ? 20 : 0), 16'h1, idxs[k], 32'hA0);
    end
    wr(flash_cmd_pkg::OFS_MODE, 32'h7);
    cmd(8'h03, 23'h000000, 16'h0001, 3'h2, 32'hA0, 1'b1);
    cmd(8'h03, 23'h7C0100, 16'h0001, 3'h2, 32'hA0);
    wr(flash_cmd_pkg::OFS_PROT, 32'hFE);
    cmd(8'h06, 23'h7E0000, 16'h0001, 3'h5, 32'h90);
    cmd(8'h06, 23'h7D0000, 16'h0001, 3'h5, 32'h80);
    cmd(8'h03, 23'h7E0000, 16'h0001, 3'h2, 32'h80);
    wr(flash_cmd_pkg::OFS_PROT, 32'h0);
    inj_err <= 1'b1;
    cmd(8'h06, 23'h7C0030, 16'h5555, 3'h5, 32'h82);
    inj_unc <= 1'b1;
    cmd(8'h06, 23'h7C0038, 16'hAAAA, 3'h5, 32'h83);
    cmd(8'h04, 23'h000002, 16'h0, 3'h1, 32'h83);
    inj_err <= 1'b0;
    inj_unc <= 1'b0;
    final_report();
  end
endmodule : tb_top
bind flash_cmd_seq flash_cmd_seq_sva chk_i (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .arr_req_o(arr_req_o),
  .arr_rsp_i(arr_rsp_i), .pflash_read_invalid(pflash_read_invalid));

// ### rtl/flash_cmd_seq.sv
// Purpose: command sequencer for section verify, one-time read and phrase program
// Assumes: array port answers each request with one ack pulse, same clock
// Notes: launch by writing 1 to the complete bit of the status register
`timescale 1ns/1ps
module flash_cmd_seq (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output flash_cmd_pkg::arr_req_t arr_req_o,
  input wire flash_cmd_pkg::arr_rsp_t arr_rsp_i,
  output logic pflash_read_invalid
);
  logic [15:0] command_param_regs [0:5];
  logic [2:0] param_slot_index_reg;
  logic command_complete_flag;
  logic access_error_flag;
  logic protection_violation_flag;
  logic verify_error_flag;
  logic verify_uncorrectable_flag;
  logic [2:0] mode_allow_reg;
  logic [7:0] prot_reg;
  flash_cmd_pkg::state_t state_reg;
  flash_cmd_pkg::op_t op_reg;
  logic [22:0] addr_reg;
  logic [15:0] left_reg;
  logic bus_req;
  logic bus_wr;
  logic launch;
  logic [7:0] cmd_code;
  logic [22:0] gaddr;
  logic [23:0] last_addr;
  logic chk_fail;
  logic viol;
  logic [7:0] status_val;
  logic addr_out;
  logic addr_unaligned;
  logic sect_bad;
  localparam int SECT = flash_cmd_pkg::SECT_SHIFT;

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
  assign launch = bus_wr && wb_adr_i == flash_cmd_pkg::OFS_STATUS
                  && wb_dat_i[flash_cmd_pkg::BIT_COMMAND_COMPLETE_FLAG] && command_complete_flag;
  assign cmd_code = command_param_regs[0][15:8];
  assign gaddr = {command_param_regs[0][6:0], command_param_regs[1]};
  assign last_addr = {1'b0, gaddr} + {5'h00, command_param_regs[2], 3'h0} - 24'h00_0001;
  // address checks shared by verify and program
  assign addr_out = gaddr < flash_cmd_pkg::PF_START || gaddr > flash_cmd_pkg::PF_END;
  assign addr_unaligned = gaddr[2:0] != 3'h0;
  // an empty section is refused too, nothing to walk
  assign sect_bad = command_param_regs[2] == 16'h0000
                    || last_addr[23:SECT] != {1'b0, gaddr[22:SECT]};

  // Status byte built bit by bit, unused bits read 0
  always_comb begin
    status_val = 8'h00;
    status_val[flash_cmd_pkg::BIT_COMMAND_COMPLETE_FLAG] = command_complete_flag;
    status_val[flash_cmd_pkg::BIT_ACCESS_ERROR_FLAG] = access_error_flag;
    status_val[flash_cmd_pkg::BIT_PROTECTION_VIOLATION_FLAG] = protection_violation_flag;
    status_val[flash_cmd_pkg::BIT_VERR] = verify_error_flag;
    status_val[flash_cmd_pkg::BIT_VUNC] = verify_uncorrectable_flag;
  end
  // Protection compares block bits against a boundary
  assign viol = prot_reg[flash_cmd_pkg::BIT_PROT_EN] && gaddr[22:16] >= prot_reg[6:0];

  // Launch-time checks, any hit means the array is never touched
  always_comb begin
    chk_fail = 1'b0;
    if (access_error_flag || protection_violation_flag) begin
      chk_fail = 1'b1;
    end
    unique case (cmd_code)
      flash_cmd_pkg::CMD_EVS: begin
        if (param_slot_index_reg != flash_cmd_pkg::IDX_EVS) begin
          chk_fail = 1'b1;
        end
        if (!mode_allow_reg[0]) begin
          chk_fail = 1'b1;
        end
        if (addr_out) begin
          chk_fail = 1'b1;
        end
        if (addr_unaligned) begin
          chk_fail = 1'b1;
        end
        if (sect_bad) begin
          chk_fail = 1'b1;
        end
      end
      flash_cmd_pkg::CMD_RDONCE: begin
        if (param_slot_index_reg != flash_cmd_pkg::IDX_RDONCE) begin
          chk_fail = 1'b1;
        end
        if (!mode_allow_reg[1]) begin
          chk_fail = 1'b1;
        end
        if (command_param_regs[1] > flash_cmd_pkg::ONCE_MAX) begin
          chk_fail = 1'b1;
        end
      end
      flash_cmd_pkg::CMD_PROG: begin
        if (param_slot_index_reg != flash_cmd_pkg::IDX_PROG) begin
          chk_fail = 1'b1;
        end
        if (!mode_allow_reg[2]) begin
          chk_fail = 1'b1;
        end
        if (addr_out) begin
          chk_fail = 1'b1;
        end
        if (addr_unaligned) begin
          chk_fail = 1'b1;
        end
      end
      default: chk_fail = 1'b1;
    endcase
  end

  // Wishbone answer, one cycle after the request, then dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h0000_0000;
      if (bus_req && !wb_we_i) begin
        unique case (wb_adr_i)
          flash_cmd_pkg::OFS_STATUS: wb_dat_o <= {24'h00_0000, status_val};
          flash_cmd_pkg::OFS_INDEX: wb_dat_o <= {29'h0000_0000, param_slot_index_reg};
          flash_cmd_pkg::OFS_PARAM: begin
            if (param_slot_index_reg <= 3'h5) begin
              wb_dat_o <= {16'h0000, command_param_regs[param_slot_index_reg]};
            end
          end
          flash_cmd_pkg::OFS_MODE: wb_dat_o <= {29'h0000_0000, mode_allow_reg};
          flash_cmd_pkg::OFS_PROT: wb_dat_o <= {24'h00_0000, prot_reg};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Configuration registers, frozen while a command runs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      param_slot_index_reg <= 3'h0;
      mode_allow_reg <= flash_cmd_pkg::MODE_RESET;
      prot_reg <= flash_cmd_pkg::PROT_RESET;
    end else if (bus_wr && command_complete_flag) begin
      if (wb_adr_i == flash_cmd_pkg::OFS_INDEX) begin
        param_slot_index_reg <= wb_dat_i[2:0];
      end
      if (wb_adr_i == flash_cmd_pkg::OFS_MODE) begin
        mode_allow_reg <= wb_dat_i[2:0];
      end
      if (wb_adr_i == flash_cmd_pkg::OFS_PROT) begin
        prot_reg <= wb_dat_i[7:0];
      end
    end
  end

  // Parameter slots: software writes when idle, one-time read returns data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 6; i++) command_param_regs[i] <= 16'h0000;
    end else if (state_reg == flash_cmd_pkg::ST_WAIT && arr_rsp_i.ack
                 && op_reg == flash_cmd_pkg::OP_RDONCE) begin
      command_param_regs[2] <= arr_rsp_i.rdata[63:48];
      command_param_regs[3] <= arr_rsp_i.rdata[47:32];
      command_param_regs[4] <= arr_rsp_i.rdata[31:16];
      command_param_regs[5] <= arr_rsp_i.rdata[15:0];
    end else if (bus_wr && command_complete_flag && wb_adr_i == flash_cmd_pkg::OFS_PARAM
                 && param_slot_index_reg <= 3'h5) begin
      command_param_regs[param_slot_index_reg][7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) begin
        command_param_regs[param_slot_index_reg][15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // Sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= flash_cmd_pkg::ST_IDLE;
      op_reg <= flash_cmd_pkg::OP_EVS;
      addr_reg <= 23'h00_0000;
      left_reg <= 16'h0000;
    end else begin
      unique case (state_reg)
        flash_cmd_pkg::ST_IDLE: begin
          if (launch) begin
            addr_reg <= gaddr;
            left_reg <= command_param_regs[2];
            if (cmd_code == flash_cmd_pkg::CMD_RDONCE) begin
              addr_reg <= flash_cmd_pkg::ONCE_BASE
                          + (23'(command_param_regs[1]) << flash_cmd_pkg::ONCE_SHIFT);
            end
            unique case (cmd_code)
              flash_cmd_pkg::CMD_RDONCE: op_reg <= flash_cmd_pkg::OP_RDONCE;
              flash_cmd_pkg::CMD_PROG: op_reg <= flash_cmd_pkg::OP_PROG;
              default: op_reg <= flash_cmd_pkg::OP_EVS;
            endcase
            if (chk_fail || (cmd_code == flash_cmd_pkg::CMD_PROG && viol)) begin
              state_reg <= flash_cmd_pkg::ST_DONE;
            end else begin
              state_reg <= flash_cmd_pkg::ST_ISSUE;
            end
          end
        end
        flash_cmd_pkg::ST_ISSUE: state_reg <= flash_cmd_pkg::ST_WAIT;
        flash_cmd_pkg::ST_WAIT: begin
          if (arr_rsp_i.ack) begin
            unique case (op_reg)
              flash_cmd_pkg::OP_EVS: begin
                if (left_reg == 16'h0001) begin
                  state_reg <= flash_cmd_pkg::ST_DONE;
                end else begin
                  state_reg <= flash_cmd_pkg::ST_ISSUE;
                end
                left_reg <= left_reg - 16'h0001;
                addr_reg <= addr_reg + 23'h00_0008;
              end
              flash_cmd_pkg::OP_PROG: begin
                op_reg <= flash_cmd_pkg::OP_PROGCHK;
                state_reg <= flash_cmd_pkg::ST_ISSUE;
              end
              default: state_reg <= flash_cmd_pkg::ST_DONE;
            endcase
          end
        end
        flash_cmd_pkg::ST_DONE: state_reg <= flash_cmd_pkg::ST_IDLE;
        default: state_reg <= flash_cmd_pkg::ST_IDLE;
      endcase
    end
  end

  // Array request, one-cycle strobe per access, two per programmed phrase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arr_req_o <= '0;
    end else begin
      arr_req_o.req <= state_reg == flash_cmd_pkg::ST_ISSUE;
      arr_req_o.write <= op_reg == flash_cmd_pkg::OP_PROG;
      arr_req_o.info <= op_reg == flash_cmd_pkg::OP_RDONCE;
      arr_req_o.addr <= addr_reg;
      arr_req_o.wdata <= {command_param_regs[2], command_param_regs[3],
                          command_param_regs[4], command_param_regs[5]};
    end
  end

  // reads of program flash invalid during one-time read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pflash_read_invalid <= 1'b0;
    end else begin
      pflash_read_invalid <= !command_complete_flag && op_reg == flash_cmd_pkg::OP_RDONCE;
    end
  end

  // Status flags: software clear first, hardware set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      command_complete_flag <= 1'b1;
      access_error_flag <= 1'b0;
      protection_violation_flag <= 1'b0;
      verify_error_flag <= 1'b0;
      verify_uncorrectable_flag <= 1'b0;
    end else begin
      if (bus_wr && wb_adr_i == flash_cmd_pkg::OFS_STATUS) begin
        if (wb_dat_i[flash_cmd_pkg::BIT_ACCESS_ERROR_FLAG]) access_error_flag <= 1'b0;
        if (wb_dat_i[flash_cmd_pkg::BIT_PROTECTION_VIOLATION_FLAG]) protection_violation_flag <= 1'b0;
      end
      if (launch) begin
        command_complete_flag <= 1'b0;
        verify_error_flag <= 1'b0;
        verify_uncorrectable_flag <= 1'b0;
        if (chk_fail) access_error_flag <= 1'b1;
        if (!chk_fail && cmd_code == flash_cmd_pkg::CMD_PROG && viol) begin
          protection_violation_flag <= 1'b1;
        end
      end
      if (state_reg == flash_cmd_pkg::ST_WAIT && arr_rsp_i.ack
          && op_reg != flash_cmd_pkg::OP_PROG) begin
        if (arr_rsp_i.err) verify_error_flag <= 1'b1;
        if (arr_rsp_i.uncorr) verify_uncorrectable_flag <= 1'b1;
        if (op_reg == flash_cmd_pkg::OP_EVS && arr_rsp_i.rdata != flash_cmd_pkg::ERASED) begin
          verify_error_flag <= 1'b1;
        end
        if (op_reg == flash_cmd_pkg::OP_PROGCHK && arr_rsp_i.rdata != arr_req_o.wdata) begin
          verify_error_flag <= 1'b1;
        end
      end
      if (state_reg == flash_cmd_pkg::ST_DONE) command_complete_flag <= 1'b1;
    end
  end
endmodule : flash_cmd_seq

// ### shared/flash_cmd_pkg.sv
// Purpose: constants and carriers for the flash command sequencer
// Assumes: 32-bit classic Wishbone register port, 64-bit phrase array port
// Notes: register offsets are byte addresses
package flash_cmd_pkg;
  localparam logic [4:0] OFS_STATUS = 5'h00;
  localparam logic [4:0] OFS_INDEX = 5'h04;
  localparam logic [4:0] OFS_PARAM = 5'h08;
  localparam logic [4:0] OFS_MODE = 5'h0C;
  localparam logic [4:0] OFS_PROT = 5'h10;
  localparam int BIT_COMMAND_COMPLETE_FLAG = 7;
  localparam int BIT_ACCESS_ERROR_FLAG = 5;
  localparam int BIT_PROTECTION_VIOLATION_FLAG = 4;
  localparam int BIT_VERR = 1;
  localparam int BIT_VUNC = 0;
  localparam int BIT_PROT_EN = 7;
  localparam logic [2:0] MODE_RESET = 3'h7;
  localparam logic [7:0] PROT_RESET = 8'h00;
  localparam logic [7:0] CMD_EVS = 8'h03;
  localparam logic [7:0] CMD_RDONCE = 8'h04;
  localparam logic [7:0] CMD_PROG = 8'h06;
  localparam logic [2:0] IDX_EVS = 3'h2;
  localparam logic [2:0] IDX_RDONCE = 3'h1;
  localparam logic [2:0] IDX_PROG = 3'h5;
  localparam logic [15:0] ONCE_MAX = 16'h0007;
  localparam int SECT_SHIFT = 17;
  localparam logic [63:0] ERASED = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [22:0] PF_START = 23'h7C_0000;
  localparam logic [22:0] PF_END = 23'h7F_FFFF;
  localparam logic [22:0] ONCE_BASE = 23'h00_0000;
  localparam int ONCE_SHIFT = 3;

  typedef struct packed {
    logic req;
    logic write;
    logic info;
    logic [22:0] addr;
    logic [63:0] wdata;
  } arr_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic uncorr;
    logic [63:0] rdata;
  } arr_rsp_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ISSUE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b011
  } state_t;

  typedef enum logic [1:0] {
    OP_EVS = 2'b00,
    OP_RDONCE = 2'b01,
    OP_PROG = 2'b10,
    OP_PROGCHK = 2'b11
  } op_t;
endpackage : flash_cmd_pkg
